//--- scsr_top.v
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "scsr_defs.vh"
module scsr_top #(
  parameter DIV_W = 7,
  parameter LOCK_CYCLES = `SCSR_LOCK_CYCLES
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // pins
  input wire standby_n_in,
  // axi4-lite write address
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_awaddr_in,
  // axi4-lite write data
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  // axi4-lite write response
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output wire [1:0] s_axi_bresp_out,
  // axi4-lite read address
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [31:0] s_axi_araddr_in,
  // axi4-lite read data
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  // clock control outputs
  output wire pixel_out_clock_out,
  output wire pix_launch_out,
  output wire clk_gate_en_out,
  output wire standby_out,
  output wire soft_reset_out,
  output wire pll_power_out,
  output wire pll_locked_out,
  output wire master_clk_sel_pll_out,
  output wire [7:0] pll_mult_out,
  output wire [5:0] pll_prescale_out,
  output wire [4:0] pll_postdivide_out
);
  // =====================================================
  // registers
  reg sync_reg;
  reg chip_en_reg;
  reg inv_stby_reg;
  reg soft_rst_reg;
  reg pll_pwr_reg;
  reg pll_use_reg;
  reg [7:0] pll_m_reg;
  reg [5:0] pll_n_reg;
  reg [4:0] pll_p1_reg;
  reg [DIV_W-1:0] pix_div_reg;
  reg pix_inv_reg;
  reg pix_shift_reg;
  reg stby_d_reg;
  reg [31:0] lock_cnt_reg;
  reg locked_reg;
  // bus state
  reg aw_hold_reg;
  reg [31:0] awaddr_reg;
  reg w_hold_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  wire standby;
  wire do_write;
  wire [7:0] widx;
  wire [7:0] ridx;
  wire w_ok;
  wire r_ok;
  wire [15:0] wmerge_chip;
  wire [15:0] wmerge_pix;
  wire [15:0] wmerge_pll;
  wire [15:0] wmerge_mult;
  wire [15:0] wmerge_div;
  wire stby_enter;
  reg [31:0] rd_mux;
  reg rd_hit;

  // byte-lane merge of the low 16 bits
  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16[7:0] = strb[0] ? data[7:0] : old_val[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old_val[15:8];
    end
  endfunction

  // word index from byte address, none when unaligned or out of range
  function [7:0] word_idx;
    input [31:0] addr;
    begin
      word_idx = (addr[31:10] == 22'h0 && addr[1:0] == 2'b00) ? addr[9:2] : 8'hFF;
    end
  endfunction

  // =====================================================
  // standby
  // pin or chip enable
  assign standby = ~(standby_n_in ^ inv_stby_reg) | ~chip_en_reg;
  assign stby_enter = standby & ~stby_d_reg;

  // =====================================================
  // write channel
  assign s_axi_awready_out = ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_out = ~w_hold_reg & ~bvalid_reg;
  assign do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
  assign widx = word_idx(awaddr_reg);
  assign w_ok = (widx == `SCSR_IDX_CHIP_CTRL) ||
                (!standby && (widx == `SCSR_IDX_PIX_CTRL || widx == `SCSR_IDX_SOFT_RST ||
                 widx == `SCSR_IDX_PLL_CTRL || widx == `SCSR_IDX_PLL_MULT ||
                 widx == `SCSR_IDX_PLL_DIV));
  assign wmerge_chip = merge16({13'h0, inv_stby_reg, chip_en_reg, sync_reg}, wdata_reg, wstrb_reg);
  assign wmerge_pix = merge16({pix_inv_reg, 6'h0, pix_shift_reg, {(8-DIV_W){1'b0}}, pix_div_reg},
                              wdata_reg, wstrb_reg);
  assign wmerge_pll = merge16({14'h0, pll_use_reg, pll_pwr_reg}, wdata_reg, wstrb_reg);
  assign wmerge_mult = merge16({pll_m_reg, 2'h0, pll_n_reg}, wdata_reg, wstrb_reg);
  assign wmerge_div = merge16({11'h0, pll_p1_reg}, wdata_reg, wstrb_reg);

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= 32'h0000_0000;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SCSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= w_ok ? `SCSR_RESP_OKAY : `SCSR_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // =====================================================
  // control registers
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      {inv_stby_reg, chip_en_reg, sync_reg} <= `SCSR_RST_CHIP_CTRL;
      soft_rst_reg <= 1'b0;
      pll_pwr_reg <= 1'b0;
      pll_use_reg <= 1'b0;
      pll_m_reg <= `SCSR_RST_PLL_M;
      pll_n_reg <= `SCSR_RST_PLL_N;
      pll_p1_reg <= `SCSR_RST_PLL_P1;
      pix_div_reg <= `SCSR_RST_PIX_DIV;
      pix_inv_reg <= 1'b0;
      pix_shift_reg <= 1'b0;
      stby_d_reg <= 1'b0;
    end else begin
      stby_d_reg <= standby;
      if (do_write && w_ok) begin
        case (widx)
          `SCSR_IDX_CHIP_CTRL: begin
            sync_reg <= wmerge_chip[`SCSR_BIT_SYNC];
            chip_en_reg <= wmerge_chip[`SCSR_BIT_CHIP_EN];
            inv_stby_reg <= wmerge_chip[`SCSR_BIT_INV_STBY];
          end
          `SCSR_IDX_PIX_CTRL: begin
            pix_div_reg <= wmerge_pix[DIV_W-1:0];
            pix_shift_reg <= wmerge_pix[`SCSR_BIT_SHIFT];
            pix_inv_reg <= wmerge_pix[`SCSR_BIT_INVERT];
          end
          `SCSR_IDX_SOFT_RST: soft_rst_reg <= wstrb_reg[0] ? wdata_reg[0] : soft_rst_reg;
          `SCSR_IDX_PLL_CTRL: begin
            pll_pwr_reg <= wmerge_pll[`SCSR_BIT_PLL_PWR];
            pll_use_reg <= wmerge_pll[`SCSR_BIT_PLL_USE];
          end
          `SCSR_IDX_PLL_MULT: begin
            pll_m_reg <= wmerge_mult[15:8];
            pll_n_reg <= wmerge_mult[5:0];
          end
          `SCSR_IDX_PLL_DIV: pll_p1_reg <= wmerge_div[4:0];
          default: begin
          end
        endcase
      end
      if (soft_rst_reg) begin
        inv_stby_reg <= 1'b0;
        pix_div_reg <= `SCSR_RST_PIX_DIV;
        pix_inv_reg <= 1'b0;
        pix_shift_reg <= 1'b0;
      end
      if (stby_enter) begin
        pll_pwr_reg <= 1'b0;
        pll_use_reg <= 1'b0;
      end
    end
  end

  // =====================================================
  // pll lock timer
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      lock_cnt_reg <= 32'h0000_0000;
      locked_reg <= 1'b0;
    end else if (!pll_pwr_reg || standby) begin
      lock_cnt_reg <= 32'h0000_0000;
      locked_reg <= 1'b0;
    end else if (lock_cnt_reg >= LOCK_CYCLES - 1) begin
      locked_reg <= 1'b1;
    end else begin
      lock_cnt_reg <= lock_cnt_reg + 32'h0000_0001;
    end
  end

  // =====================================================
  // read channel
  assign ridx = word_idx(s_axi_araddr_in);
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (ridx)
      `SCSR_IDX_CHIP_CTRL: rd_mux = {29'h0, inv_stby_reg, chip_en_reg, sync_reg};
      `SCSR_IDX_PIX_CTRL: rd_mux = {16'h0, pix_inv_reg, 6'h0, pix_shift_reg, {(8-DIV_W){1'b0}}, pix_div_reg};
      `SCSR_IDX_SOFT_RST: rd_mux = {31'h0, soft_rst_reg};
      `SCSR_IDX_PLL_CTRL: rd_mux = {30'h0, pll_use_reg, pll_pwr_reg};
      `SCSR_IDX_PLL_MULT: rd_mux = {16'h0, pll_m_reg, 2'h0, pll_n_reg};
      `SCSR_IDX_PLL_DIV: rd_mux = {27'h0, pll_p1_reg};
      `SCSR_IDX_STATUS: rd_mux = {28'h0, master_clk_sel_pll_out, locked_reg, soft_rst_reg, standby};
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready_out = ~rvalid_reg;
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SCSR_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_reg <= 1'b1;
      if (standby || !rd_hit) begin
        rdata_reg <= 32'h0000_0000;
        rresp_reg <= `SCSR_RESP_SLVERR;
      end else begin
        rdata_reg <= rd_mux;
        rresp_reg <= `SCSR_RESP_OKAY;
      end
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // =====================================================
  // pixel clock
  scsr_pixel_out_clock #(
    .DIV_W(DIV_W)
  ) u_pixel_out_clock (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .divide_in(pix_div_reg),
    .invert_in(pix_inv_reg),
    .shift_in(pix_shift_reg),
    .run_in(clk_gate_en_out),
    .pixel_out_clock_out(pixel_out_clock_out),
    .launch_out(pix_launch_out)
  );

  // =====================================================
  // outputs
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign clk_gate_en_out = ~standby & ~soft_rst_reg;
  assign standby_out = standby;
  assign soft_reset_out = soft_rst_reg;
  assign pll_power_out = pll_pwr_reg;
  assign pll_locked_out = locked_reg;
  assign master_clk_sel_pll_out = pll_use_reg & pll_pwr_reg & ~standby;
  assign pll_mult_out = pll_m_reg;
  assign pll_prescale_out = pll_n_reg;
  assign pll_postdivide_out = pll_p1_reg;
endmodule // scsr_top

//--- scsr_defs.vh
// Function
// - reset pin low restores every register to default, needing no clock edges; here reset is synchronous and takes effect on a rising clk_sys_in edge
// - soft reset bit resets all registers except chip enable, sync, reset, PLL fields
// - soft reset persists until software writes the reset bit back to zero
// - pixel clock equals input clock if divider zero, else input over twice divider
// - outputs launched on rising pixel clock edge, sampled by receiver on falling
// - invert field inverts pixel clock polarity relative to data outputs
// - shift field shifts divided pixel clock phase relative to data outputs
// - PLL output is input times multiplier over (prescale+1)(postdivide+1)
// - standby entered by standby pin low or chip enable cleared
// - standby gates clocks, rejects reads, writes only chip enable and invert; here the sync bit in the same register is written as well
// - readout resumes where it stopped after standby; host pauses or restarts
// - entering standby powers down PLL; host re-enables it afterwards
`ifndef SCSR_DEFS_VH
`define SCSR_DEFS_VH
// register indices, byte address is four times the index
`define SCSR_IDX_CHIP_CTRL 8'h07
`define SCSR_IDX_PIX_CTRL 8'h0A
`define SCSR_IDX_SOFT_RST 8'h0D
`define SCSR_IDX_PLL_CTRL 8'h10
`define SCSR_IDX_PLL_MULT 8'h11
`define SCSR_IDX_PLL_DIV 8'h12
`define SCSR_IDX_STATUS 8'h30
// field positions
`define SCSR_BIT_SYNC 0
`define SCSR_BIT_CHIP_EN 1
`define SCSR_BIT_INV_STBY 2
`define SCSR_BIT_SHIFT 8
`define SCSR_BIT_INVERT 15
`define SCSR_BIT_PLL_PWR 0
`define SCSR_BIT_PLL_USE 1
// reset values
`define SCSR_RST_CHIP_CTRL 3'h2
`define SCSR_RST_PIX_DIV 7'h00
`define SCSR_RST_PLL_M 8'h10
`define SCSR_RST_PLL_N 6'h00
`define SCSR_RST_PLL_P1 5'h00
// timing
`define SCSR_CLK_HZ 25000000
`define SCSR_LOCK_US 1000
`define SCSR_LOCK_CYCLES ((`SCSR_LOCK_US * (`SCSR_CLK_HZ / 1000000)))
// axi responses
`define SCSR_RESP_OKAY 2'h0
`define SCSR_RESP_SLVERR 2'h2
`endif

//--- scsr_pixel_out_clock.v
`timescale 1ns/1ps
`include "scsr_defs.vh"
module scsr_pixel_out_clock #(
  parameter DIV_W = 7
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // control
  input wire [DIV_W-1:0] divide_in,
  input wire invert_in,
  input wire shift_in,
  input wire run_in,
  // pixel clock
  output wire pixel_out_clock_out,
  output wire launch_out
);
  reg [DIV_W-1:0] cnt_reg;
  reg [DIV_W-1:0] cnt_next;
  reg div_clk_reg;
  reg div_clk_next;
  reg dly_clk_reg;
  reg launch_reg;
  reg launch_next;
  wire [DIV_W-1:0] last_cnt;
  wire base_clk;

  assign last_cnt = divide_in - {{(DIV_W-1){1'b0}}, 1'b1};

  // =====================================================
  // divider, period twice the divider value
  // divide by two n
  always @* begin
    cnt_next = cnt_reg;
    div_clk_next = div_clk_reg;
    launch_next = 1'b0;
    if (!run_in) begin
      cnt_next = {DIV_W{1'b0}};
      div_clk_next = 1'b0;
    end else if (divide_in == {DIV_W{1'b0}}) begin
      launch_next = 1'b1;
    end else if (cnt_reg >= last_cnt) begin
      cnt_next = {DIV_W{1'b0}};
      div_clk_next = ~div_clk_reg;
      launch_next = ~div_clk_reg;
    end else begin
      cnt_next = cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cnt_reg <= {DIV_W{1'b0}};
      div_clk_reg <= 1'b0;
      dly_clk_reg <= 1'b0;
      launch_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      div_clk_reg <= div_clk_next;
      dly_clk_reg <= div_clk_reg;
      launch_reg <= launch_next;
    end
  end

  // =====================================================
  // output clock selection
  // system clock at divider zero, else divided clock, delayed one cycle when shift set
  assign base_clk = (divide_in == {DIV_W{1'b0}}) ? (clk_sys_in & run_in) :
                    (shift_in ? dly_clk_reg : div_clk_reg);
  assign pixel_out_clock_out = base_clk ^ invert_in;
  assign launch_out = launch_reg;
endmodule // scsr_pixel_out_clock

//--- scsr_top_assertions.sv
`timescale 1ns/1ps
`include "scsr_defs.vh"
module scsr_chk (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // register bus
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0] s_axi_rresp_out,
  // clock control
  input wire clk_gate_en_out,
  input wire standby_out,
  input wire soft_reset_out,
  input wire pll_power_out,
  input wire master_clk_sel_pll_out,
  input wire [7:0] pll_mult_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  // ==========
  // properties
  property p_hard_rst;
    disable iff (1'b0) !rst_n_in |=> pll_mult_out == `SCSR_RST_PLL_M && !pll_power_out && !soft_reset_out;
  endproperty
  a_hard_rst: assert property (p_hard_rst) else $error("reset values not restored");
  property p_soft_gate;
    soft_reset_out |-> !clk_gate_en_out;
  endproperty
  a_soft_gate: assert property (p_soft_gate) else $error("clocks run in soft reset");
  property p_soft_hold;
    $fell(soft_reset_out) |-> $rose(s_axi_bvalid_out);
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset dropped alone");
  property p_stby_gate;
    standby_out |-> !clk_gate_en_out;
  endproperty
  a_stby_gate: assert property (p_stby_gate) else $error("clocks run in standby");
  property p_stby_read;
    s_axi_arvalid_in && s_axi_arready_out && standby_out |=>
      s_axi_rvalid_out && s_axi_rresp_out == `SCSR_RESP_SLVERR && s_axi_rdata_out == 32'h0000_0000;
  endproperty
  a_stby_read: assert property (p_stby_read) else $error("read served in standby");
  property p_stby_pll;
    $rose(standby_out) |-> ##[1:2] (!pll_power_out && !master_clk_sel_pll_out);
  endproperty
  a_stby_pll: assert property (p_stby_pll) else $error("pll kept on in standby");
  property p_sel_src;
    master_clk_sel_pll_out |-> pll_power_out && !standby_out;
  endproperty
  a_sel_src: assert property (p_sel_src) else $error("pll selected while unusable");
  property p_rd_ans;
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_ans;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
endmodule // scsr_chk

//--- scsr_host_model.sv
`timescale 1ns/1ps
module scsr_host_model (
  // pixel bus
  input wire pixel_clk_in,
  // standby pin
  input wire stby_req_in,
  output wire standby_n_out,
  // capture count
  output reg [15:0] edges_out
);
  initial edges_out = 16'h0000;
  assign standby_n_out = !stby_req_in;
  always @(negedge pixel_clk_in) begin
    edges_out <= edges_out + 16'h0001;
  end
endmodule // scsr_host_model

//--- sensor_clock_reset_standby_tb_top.sv
`timescale 1ns/1ps
`include "scsr_defs.vh"
module sensor_clock_reset_standby_tb_top;
  localparam [31:0] adr_chip = 4 * `SCSR_IDX_CHIP_CTRL;
  localparam [31:0] adr_pix = 4 * `SCSR_IDX_PIX_CTRL;
  localparam [31:0] adr_soft = 4 * `SCSR_IDX_SOFT_RST;
  localparam [31:0] adr_pllc = 4 * `SCSR_IDX_PLL_CTRL;
  localparam [31:0] adr_mult = 4 * `SCSR_IDX_PLL_MULT;
  localparam [31:0] adr_div = 4 * `SCSR_IDX_PLL_DIV;
  localparam [31:0] adr_stat = 4 * `SCSR_IDX_STATUS;
  localparam [1:0] ok = `SCSR_RESP_OKAY;
  localparam [1:0] err = `SCSR_RESP_SLVERR;
  reg clk_sys_in, rst_n_in, stby_req;
  reg s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  reg [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in;
  reg [3:0] pb, pi, ps;
  integer n_fail, num_checks, i;
  wire standby_n_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
  wire [31:0] s_axi_rdata_out;
  wire pixel_out_clock_out, pix_launch_out, clk_gate_en_out, standby_out, soft_reset_out;
  wire pll_power_out, pll_locked_out, master_clk_sel_pll_out;
  wire [7:0] pll_mult_out;
  wire [5:0] pll_prescale_out;
  wire [4:0] pll_postdivide_out;
  wire [15:0] edges;
  scsr_top #(.LOCK_CYCLES(8)) u_scsr_top (.clk_sys_in, .rst_n_in, .standby_n_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .s_axi_rresp_out, .pixel_out_clock_out, .pix_launch_out, .clk_gate_en_out,
    .standby_out, .soft_reset_out, .pll_power_out, .pll_locked_out, .master_clk_sel_pll_out,
    .pll_mult_out, .pll_prescale_out, .pll_postdivide_out);
  scsr_host_model u_scsr_host_model (.pixel_clk_in(pixel_out_clock_out), .stby_req_in(stby_req),
    .standby_n_out(standby_n_in), .edges_out(edges));
  // ==========
  // tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input is_wr, input [31:0] adr, input [31:0] dat, input [1:0] rsp);
    integer n;
    begin
      n = 0;
      s_axi_awaddr_in <= adr;
      s_axi_araddr_in <= adr;
      s_axi_wdata_in <= dat;
      s_axi_awvalid_in <= is_wr;
      s_axi_wvalid_in <= is_wr;
      s_axi_bready_in <= is_wr;
      s_axi_arvalid_in <= !is_wr;
      s_axi_rready_in <= !is_wr;
      while (n < 50) begin
        @(posedge clk_sys_in);
        n = n + 1;
        if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
        if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
        if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
        if (s_axi_bready_in && s_axi_bvalid_out === 1'b1) begin
          chk(s_axi_bresp_out, rsp);
          s_axi_bready_in <= 1'b0;
          n = 99;
        end
        if (s_axi_rready_in && s_axi_rvalid_out === 1'b1) begin
          chk(s_axi_rdata_out, dat);
          chk(s_axi_rresp_out, rsp);
          s_axi_rready_in <= 1'b0;
          n = 99;
        end
      end
      chk(n, 99);
      @(posedge clk_sys_in);
    end
  endtask
  task meas(input [15:0] exp);
    reg [15:0] e0;
    begin
      repeat (8) @(posedge clk_sys_in);
      #1;
      e0 = edges;
      repeat (48) @(posedge clk_sys_in);
      #1;
      chk(edges - e0, exp);
      @(posedge clk_sys_in);
    end
  endtask
  task pat(output [3:0] p);
    integer n, k;
    begin
      n = 0;
      repeat (8) @(posedge clk_sys_in);
      #1;
      while (pix_launch_out !== 1'b1 && n < 50) begin
        @(posedge clk_sys_in);
        #1;
        n = n + 1;
      end
      for (k = 0; k < 4; k = k + 1) begin
        p[k] = pixel_out_clock_out;
        @(posedge clk_sys_in);
        #1;
      end
      @(posedge clk_sys_in);
    end
  endtask
  task end_of_test;
    begin
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // ==========
  // stimulus
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    n_fail = 0;
    num_checks = 0;
    {rst_n_in, stby_req, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 5'h00;
    {s_axi_arvalid_in, s_axi_rready_in} = 2'h0;
    {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in} = 96'h0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(0, adr_chip, 32'h0000_0002, ok);
    bus(0, adr_mult, 32'h0000_1000, ok);
    bus(0, adr_pllc, 32'h0000_0000, ok);
    bus(0, 32'h0000_0400, 32'h0000_0000, err);
    bus(1, adr_stat, 32'h0000_0001, err);
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, adr_pix, i, ok);
      meas(i == 0 ? 48 : 48 / (2 * i));
    end
    bus(1, adr_pix, 32'h0000_0002, ok);
    pat(pb);
    bus(1, adr_pix, 32'h0000_8002, ok);
    pat(pi);
    chk(pi, {28'h0, ~pb});
    bus(1, adr_pix, 32'h0000_0102, ok);
    pat(ps);
    chk(ps == pb, 0);
    bus(1, adr_soft, 32'h0000_0001, ok);
    bus(1, adr_mult, 32'h0000_2003, ok);
    bus(1, adr_div, 32'h0000_0001, ok);
    bus(1, adr_pllc, 32'h0000_0001, ok);
    repeat (10) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk({soft_reset_out, clk_gate_en_out, pll_power_out}, 3'b101);
    chk({pll_mult_out, pll_prescale_out, pll_postdivide_out}, {8'h20, 6'h03, 5'h01});
    @(posedge clk_sys_in);
    bus(0, adr_pix, 32'h0000_0000, ok);
    bus(0, adr_mult, 32'h0000_2003, ok);
    bus(0, adr_stat, 32'h0000_0006, ok);
    bus(1, adr_soft, 32'h0000_0000, ok);
    bus(1, adr_pllc, 32'h0000_0000, ok);
    bus(1, adr_pllc, 32'h0000_0001, ok);
    @(negedge clk_sys_in);
    chk({soft_reset_out, clk_gate_en_out, pll_locked_out}, 3'b010);
    repeat (10) @(posedge clk_sys_in);
    chk(pll_locked_out, 1);
    bus(1, adr_pllc, 32'h0000_0003, ok);
    @(negedge clk_sys_in);
    chk(master_clk_sel_pll_out, 1);
    @(posedge clk_sys_in);
    stby_req <= 1'b1;
    repeat (4) @(negedge clk_sys_in);
    chk({standby_out, clk_gate_en_out, pll_power_out, master_clk_sel_pll_out}, 4'b1000);
    @(posedge clk_sys_in);
    bus(0, adr_chip, 32'h0000_0000, err);
    bus(1, adr_pix, 32'h0000_0005, err);
    bus(1, adr_chip, 32'h0000_0006, ok);
    repeat (3) @(negedge clk_sys_in);
    chk(standby_out, 0);
    @(posedge clk_sys_in);
    stby_req <= 1'b0;
    repeat (3) @(negedge clk_sys_in);
    chk(standby_out, 1);
    @(posedge clk_sys_in);
    bus(1, adr_chip, 32'h0000_0002, ok);
    bus(1, adr_chip, 32'h0000_0000, ok);
    @(negedge clk_sys_in);
    chk(standby_out, 1);
    @(posedge clk_sys_in);
    bus(1, adr_chip, 32'h0000_0002, ok);
    bus(0, adr_pllc, 32'h0000_0000, ok);
    bus(0, adr_pix, 32'h0000_0000, ok);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(0, adr_mult, 32'h0000_1000, ok);
    end_of_test;
  end
endmodule // sensor_clock_reset_standby_tb_top
bind scsr_top scsr_chk u_scsr_chk (.clk_sys_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rvalid_out, .s_axi_rdata_out, .s_axi_rresp_out, .clk_gate_en_out, .standby_out,
  .soft_reset_out, .pll_power_out, .master_clk_sel_pll_out, .pll_mult_out);
